// File: dacc_defs.vh
/*
 converter control block: register offsets, field positions, reset values, timing counts.
 assumes inclusion by bare name from the block's design files.
*/
`ifndef DACC_DEFS_VH
`define DACC_DEFS_VH
`define DACC_ADDR_W          6
`define DACC_OFF_ACTIVATE    6'h00
`define DACC_OFF_CONFIG      6'h04
`define DACC_OFF_CONTROL     6'h08
`define DACC_OFF_CODE        6'h0c
`define DACC_CTL_POWER_BIT   0
`define DACC_CTL_RESTART_BIT 1
`define DACC_CFG_INTRL_BIT   0
`define DACC_CFG_PIN_BIT     1
`define DACC_CFG_SLEEP_BIT   2
`define DACC_CODE_W          12
`define DACC_CODE_RST        12'h000
`define DACC_CFG_RST         3'h0
`define DACC_RESTART_NS      150
`define DACC_CLK_NS          10
`define DACC_RESTART_CYC     ((`DACC_RESTART_NS + `DACC_CLK_NS - 1) / `DACC_CLK_NS)
`endif

// File: dacc_local_reset.v
/*
 block-local reset generator for the converter control block.
 assumes the soft restart request is a one-cycle pulse in the mclk_i domain.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dacc_defs.vh"
module dacc_local_reset (
    input  wire mclk_i,
    input  wire rst_i,
    input  wire restart_i,
    output reg  local_rst_o
);
    // registered so the local reset is glitch free; it lasts one cycle after a restart pulse
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            // system reset clears the registers itself; holding this high would eat the first write after release
            local_rst_o <= 1'b0;
        end else begin
            local_rst_o <= restart_i;
        end
    end
endmodule
`default_nettype wire

// File: dacc_control_regs.v
/*
 register side of one converter instance: activation, configuration, control and code registers.
 assumes a simple synchronous register port: one-cycle write or read strobe with word address.
*/
`timescale 1ns/10ps
`default_nettype none
`include "dacc_defs.vh"
module dacc_control_regs #(
    parameter CODE_W = `DACC_CODE_W
) (
    input  wire                    mclk_i,
    input  wire                    rst_i,
    input  wire [`DACC_ADDR_W-1:0] addr_i,
    input  wire                    wr_i,
    input  wire                    rd_i,
    input  wire [31:0]             wdata_i,
    input  wire                    sleep_req_i,
    output reg  [31:0]             rdata_o,
    output reg                     rvalid_o,
    output reg  [CODE_W-1:0]       code_o,
    output reg                     analog_on_o,
    output reg                     pin_buf_en_o,
    output reg                     intrl_buf_en_o,
    output reg                     restart_busy_o
);
    reg                    activate;
    reg                    converter_power_flag;
    reg [2:0]              config_bits;
    reg [CODE_W-1:0]       code;
    reg [3:0]              restart_cnt;
    wire                   local_rst;
    wire                   restart_req;
    wire                   wr_ctl;
    wire                   asleep;
    reg  [31:0]            next_rdata;

    localparam integer     RESTART_CYC  = `DACC_RESTART_CYC;
    localparam [3:0]       RESTART_LOAD = RESTART_CYC[3:0];

    // converter may drive only when active, powered and not put to sleep
    function drive_ok;
        input act;
        input pwr;
        input slp;
        begin
            drive_ok = act && pwr && !slp;
        end
    endfunction

    assign wr_ctl      = wr_i && (addr_i == `DACC_OFF_CONTROL);
    // only a one in the restart bit acts; a zero is ignored
    assign restart_req = wr_ctl && wdata_i[`DACC_CTL_RESTART_BIT];
    assign asleep      = config_bits[`DACC_CFG_SLEEP_BIT] && sleep_req_i;

    dacc_local_reset u_local_reset (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .restart_i   (restart_req),
        .local_rst_o (local_rst)
    );

    // activation survives the soft restart, only system reset or a zero write to it clears it
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            activate <= 1'b0;
        end else if (wr_i && addr_i == `DACC_OFF_ACTIVATE) begin
            activate <= wdata_i[0];
        end
    end

    // local reset is synchronous here so it never races the write that raised it
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            converter_power_flag <= 1'b0;
            config_bits          <= `DACC_CFG_RST;
            code                 <= `DACC_CODE_RST;
        end else if (local_rst) begin
            converter_power_flag <= 1'b0;
            config_bits          <= `DACC_CFG_RST;
            code                 <= `DACC_CODE_RST;
        end else if (wr_i) begin
            case (addr_i)
                `DACC_OFF_CONFIG: begin
                    if (!converter_power_flag) begin
                        config_bits <= wdata_i[2:0];
                    end
                end
                `DACC_OFF_CONTROL: begin
                    // a restart write wins over the power bit in the same word
                    if (!wdata_i[`DACC_CTL_RESTART_BIT]) begin
                        converter_power_flag <= wdata_i[`DACC_CTL_POWER_BIT];
                    end
                end
                `DACC_OFF_CODE: begin
                    code <= wdata_i[CODE_W-1:0]; // whole field in one access
                end
                default: begin
                end
            endcase
        end
    end

    // settle counter shows software when the 150 ns wait has elapsed
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            restart_cnt <= 4'h0;
        end else if (restart_req) begin
            restart_cnt <= RESTART_LOAD;
        end else if (restart_cnt != 4'h0) begin
            restart_cnt <= restart_cnt - 4'h1;
        end
    end

    always @* begin
        next_rdata = 32'h0000_0000;
        case (addr_i)
            `DACC_OFF_ACTIVATE: next_rdata[0]   = activate;
            `DACC_OFF_CONFIG:   next_rdata[2:0] = config_bits;
            // restart bit always reads zero
            `DACC_OFF_CONTROL:  next_rdata[0]   = converter_power_flag;
            `DACC_OFF_CODE:     next_rdata[CODE_W-1:0] = code;
            default:            next_rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o        <= 32'h0000_0000;
            rvalid_o       <= 1'b0;
            code_o         <= `DACC_CODE_RST;
            analog_on_o    <= 1'b0;
            pin_buf_en_o   <= 1'b0;
            intrl_buf_en_o <= 1'b0;
            restart_busy_o <= 1'b0;
        end else begin
            rvalid_o       <= rd_i;
            if (rd_i) begin
                rdata_o <= next_rdata;
            end
            code_o         <= code;
            // inactive block cannot be powered regardless of the flag
            analog_on_o    <= drive_ok(activate, converter_power_flag, asleep);
            pin_buf_en_o   <= drive_ok(activate, converter_power_flag, asleep) && config_bits[`DACC_CFG_PIN_BIT];
            intrl_buf_en_o <= drive_ok(activate, converter_power_flag, asleep) && config_bits[`DACC_CFG_INTRL_BIT];
            restart_busy_o <= restart_req || (restart_cnt > 4'h1);
        end
    end
endmodule
`default_nettype wire

// File: dacc_props.sv
/* checker for the converter register block: restart, code path, gating and read-back.
   assumes it is bound into dacc_control_regs and sees only its ports. */
`timescale 1ns/10ps
`default_nettype none
module dacc_props #(parameter CODE_W = 12) (
    input wire logic mclk_i, rst_i, wr_i, rd_i, sleep_req_i, rvalid_o,
    input wire logic analog_on_o, pin_buf_en_o, intrl_buf_en_o, restart_busy_o,
    input wire logic [5:0] addr_i,
    input wire logic [31:0] wdata_i, rdata_o,
    input wire logic [CODE_W-1:0] code_o);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    sequence s_rst; wr_i && addr_i == 6'h08 && wdata_i[1]; endsequence
    sequence s_code; wr_i && addr_i == 6'h0c && !restart_busy_o; endsequence
    sequence s_act0; wr_i && addr_i == 6'h00 && !wdata_i[0]; endsequence
    // outputs trail the registers by a cycle, so the clear shows three edges on and still holds at the fourth
    chk_restart_clears: assert property (s_rst |-> ##4 code_o == 0 && !analog_on_o)
        else $error("restart left state");
    chk_zero_noop: assert property (wr_i && addr_i == 6'h08 && !wdata_i[1] && !restart_busy_o |=> !restart_busy_o)
        else $error("zero write restarted");
    chk_ctl_read: assert property (rvalid_o && $past(addr_i) == 6'h08 |-> rdata_o[31:1] == 0)
        else $error("control read bits");
    chk_code_write: assert property (s_code |=> ##1 code_o == $past(wdata_i[CODE_W-1:0], 2))
        else $error("code not stored");
    chk_code_read: assert property (rvalid_o && $past(addr_i) == 6'h0c |-> rdata_o[31:12] == 0)
        else $error("code upper bits");
    chk_buf_gate: assert property (pin_buf_en_o || intrl_buf_en_o |-> analog_on_o)
        else $error("buffer without power");
    chk_cfg_locked: assert property (analog_on_o && $past(analog_on_o) |-> $stable(pin_buf_en_o) && $stable(intrl_buf_en_o))
        else $error("config moved while on");
    chk_act_off: assert property (s_act0 |=> ##1 !analog_on_o)
        else $error("on while inactive");
endmodule
bind dacc_control_regs dacc_props #(.CODE_W(CODE_W)) i_props (.mclk_i(mclk_i), .rst_i(rst_i), .wr_i(wr_i),
    .rd_i(rd_i), .sleep_req_i(sleep_req_i), .rvalid_o(rvalid_o), .analog_on_o(analog_on_o), .addr_i(addr_i),
    .pin_buf_en_o(pin_buf_en_o), .intrl_buf_en_o(intrl_buf_en_o), .restart_busy_o(restart_busy_o),
    .wdata_i(wdata_i), .rdata_o(rdata_o), .code_o(code_o));
`default_nettype wire

// File: dacc_fw_model.sv
/* firmware-side register port model: one-cycle write and read strobes.
   assumes the synchronous word port of dacc_control_regs. */
`timescale 1ns/10ps
`default_nettype none
module dacc_fw_model (
    input  wire logic        mclk_i,
    input  wire logic [31:0] rdata_i,
    output logic      [5:0]  addr_o,
    output logic             wr_o,
    output logic             rd_o,
    output logic      [31:0] wdata_o);
    initial begin addr_o = 0; wr_o = 0; rd_o = 0; wdata_o = 0; end
    // whole word per access, all code bits at once
    task wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk_i); addr_o <= a; wdata_o <= d; wr_o <= 1;
        @(posedge mclk_i); wr_o <= 0; wdata_o <= ~d;
    endtask
    task rd(input logic [5:0] a, output logic [31:0] d);
        @(posedge mclk_i); addr_o <= a; rd_o <= 1;
        @(posedge mclk_i); rd_o <= 0; #1 d = rdata_i;
    endtask
endmodule
`default_nettype wire

// File: tb_dacc_control_regs.sv
/* self-checking bench for the converter register block.
   assumes dacc_props is bound in and dacc_fw_model drives the port. */
`timescale 1ns/10ps
`default_nettype none
module tb_dacc_control_regs;
    logic mclk_i = 0, rst_i = 1, sleep_req_i = 0, rvalid_o, wr_i, rd_i;
    logic analog_on_o, pin_buf_en_o, intrl_buf_en_o, restart_busy_o;
    logic [5:0] addr_i;
    logic [31:0] wdata_i, rdata_o, r, d;
    logic [11:0] code_o;
    integer seed = 59, n_fail = 0, n_compared = 0, cyc = 0, k;
    initial forever #5 mclk_i = ~mclk_i;
    dacc_control_regs i_dacc_control_regs (.mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i),
        .rd_i(rd_i), .wdata_i(wdata_i), .sleep_req_i(sleep_req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
        .code_o(code_o), .analog_on_o(analog_on_o), .pin_buf_en_o(pin_buf_en_o),
        .intrl_buf_en_o(intrl_buf_en_o), .restart_busy_o(restart_busy_o));
    dacc_fw_model fw (.mclk_i(mclk_i), .rdata_i(rdata_o), .addr_o(addr_i), .wr_o(wr_i), .rd_o(rd_i),
        .wdata_o(wdata_i));
    task chk(input logic [31:0] s, e);
        n_compared++;
        if (s !== e) begin n_fail++; $display("[FAIL] t=%0t seen %h exp %h", $time, s, e); end
    endtask
    function logic [31:0] exp_code(input logic [31:0] v); return {20'h0, v[11:0]}; endfunction
    task rchk(input logic [5:0] a, input logic [31:0] e); fw.rd(a, r); chk(r, e); endtask
    task end_of_test;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin n_fail++; end_of_test; end
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        rst_i <= 0;
        for (k = 0; k < 5; k++) rchk({k[3:0], 2'b00}, 0);
        $display("test reset done");
        for (k = 0; k < 6; k++) begin
            d = (k == 0) ? 32'hffff_ffff : $random(seed);
            fw.wr(6'h0c, d);
            @(posedge mclk_i); #1;
            chk({20'h0, code_o}, exp_code(d));
            rchk(6'h0c, exp_code(d));
        end
        $display("test code done");
        fw.wr(6'h00, 1); fw.wr(6'h04, 3); fw.wr(6'h08, 1);
        @(posedge mclk_i); #1;
        chk({29'h0, analog_on_o, pin_buf_en_o, intrl_buf_en_o}, 7);
        @(posedge mclk_i) sleep_req_i <= 1;
        repeat (2) @(posedge mclk_i); #1;
        chk({29'h0, analog_on_o, pin_buf_en_o, intrl_buf_en_o}, 7);
        @(posedge mclk_i) sleep_req_i <= 0;
        fw.wr(6'h04, 4); rchk(6'h04, 3);
        fw.wr(6'h08, 1); rchk(6'h0c, exp_code(d));
        $display("test power done");
        fw.wr(6'h08, 3);
        #1 chk({31'h0, restart_busy_o}, 1);
        repeat (14) @(posedge mclk_i); #1;
        chk({31'h0, restart_busy_o}, 1);
        @(posedge mclk_i); #1;
        chk({31'h0, restart_busy_o}, 0); // restart settles before power-on
        rchk(6'h08, 0);
        rchk(6'h0c, 0);
        rchk(6'h04, 0);
        rchk(6'h00, 1);
        fw.wr(6'h00, 0); fw.wr(6'h08, 1);
        @(posedge mclk_i); #1;
        chk({31'h0, analog_on_o}, 0);
        $display("test restart done");
        end_of_test;
    end
endmodule
`default_nettype wire
